// ==== design/adcci_top.sv ====
// Converter control block: channel, clock and power control, start pulse
// detection, done flag, result register and a level interrupt.
// Assumes an 8-bit register port with single-cycle strobes and a comparator
// whose result is synchronous to ref_clk.
`timescale 1ns/1ps

// Function
// [R1] Six inputs, each converted to 8 bits
// [R2] Three-bit field picks input or reference
// [R3] Two-bit field divides the conversion clock
// [R4] Start after full low-high-low pulse
// [R5] Rising start resets converter, clears result
// [R6] Converter runs only while power bit set
// [R7] Done flag reads zero after completion
// [R8] Separate read-only register holds result
// [R9] Inputs share port B pins
// [R10] Unused analog pins stay general I/O
// [R11] Build option removes whole converter
// [R12] Reference select bit, default supply rails
// [R13] Done flag high while converting
module adcci_top
  import adcci_pkg::*;
#(
  parameter bit CONVERTER_PRESENT = 1'b1     // Build-time presence option
)(
  input  wire logic                    ref_clk,     // System clock
  input  wire logic                    rst,         // Sync reset
  input  wire logic [adcci_pkg::ADDR_W-1:0] addr,   // Register address
  input  wire logic [adcci_pkg::DATA_W-1:0] wdata,  // Write data
  input  wire logic                    wr,          // Write strobe
  input  wire logic                    rd,          // Read strobe
  output logic [adcci_pkg::DATA_W-1:0] rdata,       // Read data, next cycle
  input  wire logic                    cmp_hi,      // Comparator answer
  output logic [adcci_pkg::DATA_W-1:0] dac_code,    // Trial code
  output logic [2:0]                   analog_sel,  // Mux select
  output logic                         converter_power_on, // Analog power
  output logic                         reference_from_supply, // Ref source
  output logic [7:0]                   port_b_analog, // Pin in analog use
  output logic                         irq          // Level interrupt
);
  import adcci_pkg::*;

  logic [2:0]        channel_select;
  logic              conv_clock_select_hi;
  logic              conv_clock_select_lo;
  logic              start_reg;
  logic              armed_reg;
  logic              conversion_done_n;
  logic [DATA_W-1:0] result_bits;
  logic [IRQ_W-1:0]  irq_status_reg;
  logic [IRQ_W-1:0]  irq_enable_reg;
  logic [DIV_W-1:0]  div_cnt_reg;
  logic [3:0]        pre_cnt_reg;
  logic              tick;
  logic              core_busy;
  logic              core_done;
  logic [DATA_W-1:0] core_result;
  logic [DATA_W-1:0] core_trial;
  logic              go_pulse;
  logic              clr_pulse;
  logic              wr_ctrl;
  logic [DATA_W-1:0] rdata_next;

  // Address decode, used by write path and read path
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Divider count for each clock code: 6, 3, 1.5, 0.75 MHz
  function automatic logic [3:0] pre_limit(input logic [1:0] sel);
    case (sel)
      2'b00:   pre_limit = 4'h0;
      2'b01:   pre_limit = 4'h1;
      2'b10:   pre_limit = 4'h3;
      2'b11:   pre_limit = 4'h7;
      default: pre_limit = 4'h0;
    endcase
  endfunction

  assign wr_ctrl = wr && hit(addr, OFS_CTRL_STATUS);
  // Start edges: rising clears, falling after a rise launches
  assign clr_pulse = wr_ctrl && wdata[START_BIT] && !start_reg;    // [R5]
  // The fall must also keep power on, or the launch is lost to the abort
  assign go_pulse  = wr_ctrl && !wdata[START_BIT] && start_reg &&
                     armed_reg && converter_power_on &&
                     wdata[POWER_BIT];                             // [R4]

  // Control fields written by firmware
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      channel_select       <= CTRL_RESET[2:0];
      conv_clock_select_lo <= 1'b0;
      conv_clock_select_hi <= 1'b0;
      start_reg            <= 1'b0;
      converter_power_on   <= 1'b0;
    end else if (wr_ctrl && CONVERTER_PRESENT) begin               // [R11]
      channel_select       <= wdata[CHAN_LSB +: 3];                // [R2]
      conv_clock_select_lo <= wdata[CLKSEL_LO_BIT];                // [R3]
      conv_clock_select_hi <= wdata[CLKSEL_HI_BIT];                // [R3]
      start_reg            <= wdata[START_BIT];
      converter_power_on   <= wdata[POWER_BIT];                    // [R6]
    end
  end

  // A falling start only counts once its matching rise was seen
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      armed_reg <= 1'b0;
    end else if (clr_pulse) begin
      armed_reg <= 1'b1;                                           // [R4]
    end else if (go_pulse || (wr_ctrl && !wdata[START_BIT])) begin
      armed_reg <= 1'b0;
    end
  end

  // Reference source lives in a neighbouring status register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reference_from_supply <= REF_SUPPLY_RST;                     // [R12]
    end else if (wr && hit(addr, OFS_REF_SELECT)) begin
      reference_from_supply <= wdata[REF_SUPPLY_BIT];              // [R12]
    end
  end

  // Conversion clock enable: a 6 MHz base, then a power-of-two prescale.
  // The base divisor rounds down, so the clock runs a little fast.
  // Restarted on launch so the first tick never meets a stale trial code.
  always_ff @(posedge ref_clk) begin
    if (rst || !converter_power_on || go_pulse) begin
      div_cnt_reg <= '0;
      pre_cnt_reg <= '0;
      tick        <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (div_cnt_reg == DIV_W'(CONV_DIV0 - 1)) begin
        div_cnt_reg <= '0;
        if (pre_cnt_reg >= pre_limit({conv_clock_select_hi,
                                      conv_clock_select_lo})) begin
          pre_cnt_reg <= '0;
          tick        <= 1'b1;                                     // [R3]
        end else begin
          pre_cnt_reg <= pre_cnt_reg + 4'h1;
        end
      end else begin
        div_cnt_reg <= div_cnt_reg + DIV_W'(1);
      end
    end
  end

  // Approximation engine; power loss aborts it like a restart
  adcci_conv_core u_core (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clr     (clr_pulse || !converter_power_on),                   // [R6]
    .go      (go_pulse && CONVERTER_PRESENT),
    .tick    (tick),
    .cmp_hi  (cmp_hi),
    .trial   (core_trial),
    .result  (core_result),
    .busy    (core_busy),
    .done    (core_done)
  );

  // Done flag: high from launch until the result is stored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conversion_done_n <= 1'b0;
    end else if (go_pulse && CONVERTER_PRESENT) begin
      conversion_done_n <= 1'b1;                                   // [R13]
    end else if (core_done || !core_busy || !converter_power_on) begin
      conversion_done_n <= 1'b0;                                   // [R7]
    end
  end

  // Result register, cleared by a rising start
  always_ff @(posedge ref_clk) begin
    if (rst || clr_pulse) begin
      result_bits <= RESULT_RESET;                                 // [R5]
    end else if (core_done) begin
      result_bits <= core_result;                                  // [R8]
    end
  end

  // Interrupt: completion is sticky; set wins over a same-cycle clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_status_reg <= '0;
      irq_enable_reg <= '0;
    end else begin
      if (wr && hit(addr, OFS_IRQ_ENABLE)) begin
        irq_enable_reg <= wdata[IRQ_W-1:0];
      end
      for (int i = 0; i < IRQ_W; i++) begin
        if (i == IRQ_DONE_BIT && core_done) begin
          irq_status_reg[i] <= 1'b1;
        end else if (wr && hit(addr, OFS_IRQ_CLEAR) && wdata[i]) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt output registered so it comes straight from a flop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_next() & irq_enable_reg);
    end
  end

  // Status value as it will stand after this edge, for a registered irq
  function automatic logic [IRQ_W-1:0] irq_status_next();
    logic [IRQ_W-1:0] s;
    s = irq_status_reg;
    if (wr && hit(addr, OFS_IRQ_CLEAR)) begin
      s = s & ~wdata[IRQ_W-1:0];
    end
    if (core_done) begin
      s[IRQ_DONE_BIT] = 1'b1;
    end
    return s;
  endfunction

  // Analog routing: the selected pin, and pins 6 and 7 under external references, leave general I/O use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      analog_sel    <= '0;
      dac_code      <= '0;
      port_b_analog <= '0;
    end else begin
      analog_sel <= channel_select;                                // [R1]
      dac_code   <= core_trial;
      for (int p = 0; p < 8; p++) begin
        // Inputs on pins 0-5, low ref on 6, high ref on 7
        port_b_analog[p] <= converter_power_on && CONVERTER_PRESENT &&
                            pin_used(3'(p));                       // [R9]
      end                                                          // [R10]
    end
  end

  // Whether a port B pin is claimed by the converter
  function automatic logic pin_used(input logic [2:0] p);
    if (p <= CHAN_AN5) begin
      pin_used = (channel_select == p);                            // [R9]
    end else if (p == CHAN_LOW_REF) begin
      pin_used = !reference_from_supply ||
                 (channel_select == CHAN_LOW_REF);
    end else begin
      pin_used = !reference_from_supply ||
                 (channel_select == CHAN_HIGH_REF);
    end
  endfunction

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = '0;
    if (hit(addr, OFS_CTRL_STATUS)) begin
      rdata_next = {conversion_done_n, converter_power_on, start_reg,
                    conv_clock_select_hi, conv_clock_select_lo,
                    channel_select};
    end else if (hit(addr, OFS_RESULT)) begin
      rdata_next = result_bits;                                    // [R8]
    end else if (hit(addr, OFS_REF_SELECT)) begin
      rdata_next[REF_SUPPLY_BIT] = reference_from_supply;
    end else if (hit(addr, OFS_IRQ_STATUS)) begin
      rdata_next[IRQ_W-1:0] = irq_status_reg;
    end else if (hit(addr, OFS_IRQ_ENABLE)) begin
      rdata_next[IRQ_W-1:0] = irq_enable_reg;
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (rst || !rd) begin
      rdata <= '0;
    end else begin
      rdata <= rdata_next;
    end
  end
endmodule

// ==== design/adcci_pkg.sv ====
// Package for the converter control block: register offsets, fields,
// reset values and timing counts.
// Assumes a 125 MHz ref_clk and an 8-bit register port.
package adcci_pkg;
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 8;
  // Register offsets
  localparam logic [7:0] OFS_CTRL_STATUS  = 8'h1d;
  localparam logic [7:0] OFS_RESULT       = 8'h1e;
  localparam logic [7:0] OFS_REF_SELECT   = 8'h1b;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLEAR    = 8'h21;
  localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h22;
  // Control/status field positions
  localparam int unsigned CHAN_LSB        = 0;
  localparam int unsigned CLKSEL_LO_BIT   = 3;
  localparam int unsigned CLKSEL_HI_BIT   = 4;
  localparam int unsigned START_BIT       = 5;
  localparam int unsigned POWER_BIT       = 6;
  localparam int unsigned DONE_N_BIT      = 7;
  localparam int unsigned REF_SUPPLY_BIT  = 6;
  // Reset values
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam logic [7:0] RESULT_RESET     = 8'h00;
  localparam logic       REF_SUPPLY_RST   = 1'b1;
  // Interrupt status bits
  localparam int unsigned IRQ_DONE_BIT    = 0;
  localparam int unsigned IRQ_W           = 1;
  // Channel codes
  localparam logic [2:0] CHAN_AN5         = 3'h5;
  localparam logic [2:0] CHAN_LOW_REF     = 3'h6;
  localparam logic [2:0] CHAN_HIGH_REF    = 3'h7;
  localparam int unsigned NUM_INPUTS      = 6;
  // Timing: fastest conversion clock and the divider from ref_clk
  localparam int unsigned REF_CLK_KHZ     = 125000;
  localparam int unsigned CONV_CLK0_KHZ   = 6000;
  localparam int unsigned CONV_DIV0       =
    REF_CLK_KHZ / CONV_CLK0_KHZ;          // Shortest period rounds down
  localparam int unsigned DIV_W           = 8;
  // Conversion clocks per result (one per bit plus two extra slots)
  localparam int unsigned CONV_TICKS      = 10;
endpackage

// ==== design/adcci_conv_core.sv ====
// Successive-approximation sequencer behind the control register.
// Assumes the analog comparator answers within one conversion tick.
`timescale 1ns/1ps
module adcci_conv_core
  import adcci_pkg::*;
(
  input  wire logic              ref_clk,    // System clock
  input  wire logic              rst,        // Sync reset, active high
  input  wire logic              clr,        // Abort and clear result
  input  wire logic              go,         // Start pulse
  input  wire logic              tick,       // Conversion clock enable
  input  wire logic              cmp_hi,     // Input above trial level
  output logic [DATA_W-1:0]      trial,      // Trial code to the DAC
  output logic [DATA_W-1:0]      result,     // Finished result
  output logic                   busy,       // Conversion running
  output logic                   done        // One-cycle completion pulse
);
  logic [DATA_W-1:0] mask_reg;
  logic [3:0]        step_reg;

  // Bit-by-bit approximation, MSB first
  always_ff @(posedge ref_clk) begin
    done <= 1'b0;
    if (rst || clr) begin
      busy     <= 1'b0;
      trial    <= RESULT_RESET;
      result   <= RESULT_RESET;
      mask_reg <= '0;
      step_reg <= '0;
    end else if (go) begin
      busy     <= 1'b1;
      mask_reg <= 8'h80;
      trial    <= 8'h80;
      step_reg <= '0;
    end else if (busy && tick) begin
      step_reg <= step_reg + 4'h1;
      if (mask_reg != '0) begin
        // Keep the bit when the input sits above the trial level
        trial    <= (cmp_hi ? trial : (trial & ~mask_reg)) |
                    (mask_reg >> 1);
        mask_reg <= mask_reg >> 1;
      end
      if (step_reg == 4'(CONV_TICKS - 1)) begin
        result <= trial;
        busy   <= 1'b0;
        done   <= 1'b1;
      end
    end
  end
endmodule

// ==== sim/adcci_monitor.sv ====
// Port checks for the converter control block.
// Assumes the register map of adcci_pkg and one clock domain.
`timescale 1ns/1ps
module adcci_monitor
  import adcci_pkg::*;
(
  input wire logic                         ref_clk,  // System clock
  input wire logic                         rst,      // Sync reset
  input wire logic [adcci_pkg::ADDR_W-1:0] addr,     // Register address
  input wire logic [adcci_pkg::DATA_W-1:0] wdata,    // Write data
  input wire logic                         wr,       // Write strobe
  input wire logic                         rd,       // Read strobe
  input wire logic [adcci_pkg::DATA_W-1:0] rdata,    // Read data
  input wire logic [2:0]                   analog_sel, // Mux select
  input wire logic                         converter_power_on, // Power
  input wire logic                         reference_from_supply, // Ref
  input wire logic [7:0]                   port_b_analog, // Analog pins
  input wire logic                         irq       // Level interrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Control register decodes
  logic wr_ctrl;
  logic rd_ctrl;
  assign wr_ctrl = wr && (addr == OFS_CTRL_STATUS);
  assign rd_ctrl = rd && (addr == OFS_CTRL_STATUS);
  // Copy of the start bit, so a rise means a real low to high change
  logic start_seen;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      start_seen <= 1'b0;
    end else if (wr_ctrl) begin
      start_seen <= wdata[START_BIT];
    end
  end
  // Start pulse phases; the fall only launches with power held on
  sequence start_rise;
    wr_ctrl && wdata[START_BIT] && !start_seen;
  endsequence
  sequence start_fall;
    !wr_ctrl ##1 wr_ctrl && !wdata[START_BIT] && wdata[POWER_BIT]
      && converter_power_on;
  endsequence
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a reply");
  power_follow_a: assert property (wr_ctrl |=>
    converter_power_on == $past(wdata[POWER_BIT]))
    else $error("power output ignores control write");
  chan_follow_a: assert property (wr_ctrl |-> ##2
    analog_sel == $past(wdata[2:0], 2))
    else $error("channel output ignores control write");
  ref_follow_a: assert property (wr && addr == OFS_REF_SELECT |=>
    reference_from_supply == $past(wdata[REF_SUPPLY_BIT]))
    else $error("reference select ignores write");
  pins_match_a: assert property (converter_power_on
    && $stable(converter_power_on) && $stable(analog_sel)
    && analog_sel < 3'h6 |-> port_b_analog[5:0] == (6'h01 << analog_sel))
    else $error("analog pin map wrong");
  irq_mask_a: assert property (wr && addr == OFS_IRQ_ENABLE
    && !wdata[IRQ_DONE_BIT] |-> ##2 !irq)
    else $error("interrupt high while masked");
  clear_result_a: assert property (start_rise ##2
    (rd && addr == OFS_RESULT) |=> rdata == RESULT_RESET)
    else $error("result not cleared by start rise");
  busy_flag_a: assert property (start_rise ##1 start_fall
    ##2 rd_ctrl |=> rdata[DONE_N_BIT])
    else $error("done flag low after launch");
  power_abort_a: assert property (wr_ctrl && !wdata[POWER_BIT]
    ##2 rd_ctrl |=> !rdata[DONE_N_BIT])
    else $error("done flag high with power off");
endmodule
bind adcci_top adcci_monitor u_adcci_monitor (.ref_clk, .rst, .addr,
  .wdata, .wr, .rd, .rdata, .analog_sel, .converter_power_on,
  .reference_from_supply, .port_b_analog, .irq);

// ==== sim/tb_top.sv ====
// Self-checking bench for the converter control block.
// Assumes adcci_pkg; the bench acts as the comparator with a held level.
`timescale 1ns/1ps
module tb_top;
  import adcci_pkg::*;
  typedef struct packed {
    logic [2:0] chan;
    logic [1:0] clk;
    logic [7:0] lvl;
  } adcci_row_t;
  logic       ref_clk = 1'b0;
  logic       rst     = 1'b1;
  logic [7:0] addr    = 8'h00;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic       cmp_hi  = 1'b0;
  logic [7:0] lvl     = 8'h00;
  logic [7:0] rdata, dac_code, port_b_analog, v;
  logic [2:0] analog_sel;
  logic       converter_power_on, reference_from_supply, irq;
  int         err_total    = 0;
  int         total_checks = 0;
  int         n, t;
  adcci_row_t rows [8] = '{'{3'h0, 2'h0, 8'h5a}, '{3'h1, 2'h1, 8'h00},
    '{3'h2, 2'h2, 8'h81}, '{3'h3, 2'h3, 8'h7f}, '{3'h4, 2'h0, 8'hff},
    '{3'h5, 2'h1, 8'h01}, '{3'h6, 2'h2, 8'h00}, '{3'h7, 2'h3, 8'hc3}};
  always #4 ref_clk = ~ref_clk;
  // Analog level sits half a step above lvl, so any trial rule gives lvl
  always @(posedge ref_clk) cmp_hi <= (lvl >= dac_code);
  adcci_top u_adcci_top (.ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .cmp_hi, .dac_code, .analog_sel, .converter_power_on,
    .reference_from_supply, .port_b_analog, .irq);
  // Compare and count
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic idle(int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask
  // Poll with a bound; n counts clocks spent
  task automatic wait_done();
    n = 0;
    do begin
      rd_reg(OFS_CTRL_STATUS);
      n += 2;
    end while (v[DONE_N_BIT] === 1'b1 && n < 4000);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog sized well above the slowest conversions
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(OFS_CTRL_STATUS);
    check("ctrl_rst", v, CTRL_RESET);
    rd_reg(OFS_REF_SELECT);
    check("ref_rst", v[6], REF_SUPPLY_RST);
    wr_reg(OFS_RESULT, 8'hff);
    rd_reg(OFS_RESULT);
    check("result_ro", v, RESULT_RESET);
    rd_reg(8'h55);
    check("unmapped", v, 8'h00);
    wr_reg(OFS_IRQ_ENABLE, 8'h01);
    foreach (rows[i]) begin
      lvl = rows[i].lvl;
      wr_reg(OFS_CTRL_STATUS, {3'b011, rows[i].clk, rows[i].chan});
      wr_reg(OFS_CTRL_STATUS, {3'b010, rows[i].clk, rows[i].chan});
      rd_reg(OFS_CTRL_STATUS);
      check("busy", v[7], 1);
      check("sel", analog_sel, rows[i].chan);
      check("pins", port_b_analog[5:0],
        rows[i].chan < 6 ? 8'h01 << rows[i].chan : 8'h00);
      wait_done();
      check("eoc", v[DONE_N_BIT], 0);
      t = CONV_DIV0 << rows[i].clk;
      check("time", n >= 9 * t && n <= 11 * t, 1);
      rd_reg(OFS_RESULT);
      check("result", v, rows[i].lvl);
      check("dac", dac_code, rows[i].lvl);
      check("irq", irq, 1);
      wr_reg(OFS_IRQ_CLEAR, 8'h01);
      idle(2);
      check("irq_clr", irq, 0);
    end
    // Start rise alone wipes the last result
    wr_reg(OFS_CTRL_STATUS, 8'h60);
    rd_reg(OFS_RESULT);
    check("rise_clr", v, 8'h00);
    // Power drop in mid conversion must abort it
    wr_reg(OFS_CTRL_STATUS, 8'h40);
    idle(30);
    wr_reg(OFS_CTRL_STATUS, 8'h00);
    rd_reg(OFS_CTRL_STATUS);
    check("abort", v[7], 0);
    check("pins_off", port_b_analog, 8'h00);
    // Start written low with no rise before it launches nothing
    wr_reg(OFS_CTRL_STATUS, 8'h40);
    wr_reg(OFS_CTRL_STATUS, 8'h40);
    rd_reg(OFS_CTRL_STATUS);
    check("no_rise", v, 8'h40);
    // Masked completion keeps irq low but sets status
    wr_reg(OFS_IRQ_ENABLE, 8'h00);
    lvl = 8'h3c;
    wr_reg(OFS_CTRL_STATUS, 8'h60);
    wr_reg(OFS_CTRL_STATUS, 8'h40);
    wait_done();
    idle(2);
    check("irq_mask", irq, 0);
    rd_reg(OFS_IRQ_STATUS);
    check("irq_stat", v[0], 1);
    wr_reg(OFS_IRQ_ENABLE, 8'h01);
    idle(2);
    check("irq_unmask", irq, 1);
    // External references claim both upper pins
    wr_reg(OFS_REF_SELECT, 8'h00);
    idle(2);
    check("ref_ext", reference_from_supply, 0);
    check("ref_pins", port_b_analog[7:6], 2'b11);
    // Reset in mid conversion
    wr_reg(OFS_CTRL_STATUS, 8'h60);
    wr_reg(OFS_CTRL_STATUS, 8'h40);
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(OFS_CTRL_STATUS);
    check("rst_ctrl", v, CTRL_RESET);
    check("rst_ref", reference_from_supply, 1);
    check("rst_pwr", converter_power_on, 0);
    check("rst_irq", irq, 0);
    stop_test();
  end
endmodule
